//--- core/serial_cfg_regs.svh
`ifndef SERIAL_CFG_REGS_SVH
`define SERIAL_CFG_REGS_SVH
`define ADDR_CALIBRATION 4'h0
`define ADDR_OUTPUT_CONFIG 4'h1
`define ADDR_FIRST_OFFSET 4'h2
`define ADDR_FIRST_FULLSCALE 4'h3
`define ADDR_EXT_CONFIG 4'h9
`define ADDR_SECOND_OFFSET 4'hA
`define ADDR_SECOND_FULLSCALE 4'hB
`define ADDR_PHASE_FINE 4'hE
`define ADDR_PHASE_COARSE 4'hF
`define RST_CALIBRATION 16'h7FFF
`define RST_OUTPUT_CONFIG 16'hB2FF
`define RST_FIRST_OFFSET 16'h0000
`define RST_FIRST_FULLSCALE 16'h0000
`define RST_EXT_CONFIG 16'h0000
`define RST_SECOND_OFFSET 16'h0000
`define RST_SECOND_FULLSCALE 16'h0000
`define RST_PHASE_FINE 16'h0000
`define RST_PHASE_COARSE 16'h0000
`define FRAME_HEADER 12'h001
`define FRAME_BITS 6'h20
`define BIT_CAL_START 15
`define BIT_SECOND_CLOCK_SEL_N 13
`define BIT_DUTY_STAB 12
`define BIT_DDR_PHASE 11
`define BIT_DDR_EN_N 10
`define BIT_SWING 9
`define BIT_EDGE_DEMUX 8
`endif

//--- core/serial_cfg_pkg.sv
package serial_cfg_pkg;
    typedef struct packed {
        logic [15:0] calibration_control;
        logic [15:0] output_configuration;
        logic [15:0] first_channel_offset;
        logic [15:0] first_channel_fullscale;
        logic [15:0] extended_configuration;
        logic [15:0] second_channel_offset;
        logic [15:0] second_channel_fullscale;
        logic [15:0] sample_phase_fine;
        logic [15:0] sample_phase_coarse;
    } reg_bank_t;
    typedef struct packed {
        logic second_clock_select_n;
        logic duty_stabilizer_enable;
        logic ddr_clock_phase;
        logic ddr_enable_n;
        logic output_swing_select;
        logic edge_and_demux_select;
    } out_cfg_t;
endpackage : serial_cfg_pkg

//--- core/converter_serial_config_registers.sv
`timescale 1ns/1ns
`include "serial_cfg_regs.svh"
module converter_serial_config_registers (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Mode and power
    input wire logic extended_mode,
    input wire logic power_down,
    // Serial link pins
    input wire logic serial_clock,
    input wire logic serial_select_n,
    input wire logic serial_data_in,
    // Active settings
    output serial_cfg_pkg::reg_bank_t active_regs,
    output serial_cfg_pkg::out_cfg_t out_cfg,
    output logic calibration_start,
    // Output pin sharing
    output logic second_clock_on_range_pins,
    output logic range_output_enable,
    // Frame status
    output logic frame_written
);
    serial_cfg_pkg::reg_bank_t bank_value;
    serial_cfg_pkg::reg_bank_t default_bank;
    serial_cfg_pkg::reg_bank_t active_next;
    logic [15:0] calibration_control_reg;
    logic [15:0] output_configuration_reg;
    logic [15:0] first_channel_offset_reg;
    logic [15:0] first_channel_fullscale_reg;
    logic [15:0] extended_configuration_reg;
    logic [15:0] second_channel_offset_reg;
    logic [15:0] second_channel_fullscale_reg;
    logic [15:0] sample_phase_fine_reg;
    logic [15:0] sample_phase_coarse_reg;
    logic [2:0] sclk_sync_reg;
    logic [2:0] ssel_sync_reg;
    logic [2:0] sdat_sync_reg;
    logic sclk_state_reg;
    logic ssel_state_reg;
    logic sclk_settled;
    logic ssel_settled;
    logic [31:0] shift_reg;
    logic [5:0] count_reg;
    logic rise;
    logic selected;
    logic [31:0] frame_next;
    logic frame_done;
    logic header_ok;
    logic frame_accept;
    logic [3:0] frame_addr;
    logic [15:0] frame_data;
    logic [8:0] write_sel;
    logic [15:0] config_next;
    logic [15:0] config_default;
    logic cal_request;

    assign default_bank = {`RST_CALIBRATION, `RST_OUTPUT_CONFIG, `RST_FIRST_OFFSET,
        `RST_FIRST_FULLSCALE, `RST_EXT_CONFIG, `RST_SECOND_OFFSET,
        `RST_SECOND_FULLSCALE, `RST_PHASE_FINE, `RST_PHASE_COARSE};

    // Write-only bank: nothing leads back to the link
    assign bank_value = {calibration_control_reg, output_configuration_reg,
        first_channel_offset_reg, first_channel_fullscale_reg, extended_configuration_reg,
        second_channel_offset_reg, second_channel_fullscale_reg, sample_phase_fine_reg,
        sample_phase_coarse_reg};

    // Pins are asynchronous to clk: three stages; clock and select change once last two agree
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_sync_reg <= 3'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], serial_clock};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ssel_sync_reg <= 3'h7;
        end else begin
            ssel_sync_reg <= {ssel_sync_reg[1:0], serial_select_n};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sdat_sync_reg <= 3'h0;
        end else begin
            sdat_sync_reg <= {sdat_sync_reg[1:0], serial_data_in};
        end
    end

    assign sclk_settled = sclk_sync_reg[2] == sclk_sync_reg[1];
    assign ssel_settled = ssel_sync_reg[2] == ssel_sync_reg[1];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_state_reg <= 1'b0;
        end else if (sclk_settled) begin
            sclk_state_reg <= sclk_sync_reg[2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ssel_state_reg <= 1'b1;
        end else if (ssel_settled) begin
            ssel_state_reg <= ssel_sync_reg[2];
        end
    end

    // Data sampled at the settled rising edge of the serial clock
    assign rise = sclk_settled && sclk_sync_reg[2] && !sclk_state_reg;
    assign selected = !ssel_state_reg && !ssel_sync_reg[2];
    assign frame_next = {shift_reg[30:0], sdat_sync_reg[2]};
    assign frame_done = rise && selected && (count_reg == `FRAME_BITS - 6'h01);
    assign header_ok = frame_next[31:20] == `FRAME_HEADER;
    assign frame_accept = frame_done && header_ok;
    assign frame_addr = frame_next[19:16];
    assign frame_data = frame_next[15:0];

    // Serial link is only live in extended mode
    always_ff @(posedge clk) begin
        if (!rst_b || !selected || !extended_mode) begin
            shift_reg <= 32'h0000_0000;
        end else if (rise) begin
            shift_reg <= frame_next;
        end
    end

    // Counter wraps so a new frame starts on the 33rd edge
    always_ff @(posedge clk) begin
        if (!rst_b || !selected || !extended_mode) begin
            count_reg <= 6'h00;
        end else if (rise) begin
            count_reg <= frame_done ? 6'h00 : count_reg + 6'h01;
        end
    end

    // One strobe per register; reserved addresses select nothing
    always_comb begin
        write_sel = 9'h000;
        if (frame_accept) begin
            unique case (frame_addr)
                `ADDR_CALIBRATION: write_sel = 9'h001;
                `ADDR_OUTPUT_CONFIG: write_sel = 9'h002;
                `ADDR_FIRST_OFFSET: write_sel = 9'h004;
                `ADDR_FIRST_FULLSCALE: write_sel = 9'h008;
                `ADDR_EXT_CONFIG: write_sel = 9'h010;
                `ADDR_SECOND_OFFSET: write_sel = 9'h020;
                `ADDR_SECOND_FULLSCALE: write_sel = 9'h040;
                `ADDR_PHASE_FINE: write_sel = 9'h080;
                `ADDR_PHASE_COARSE: write_sel = 9'h100;
                default: write_sel = 9'h000;
            endcase
        end
    end

    // Registers ignore power_down, so contents survive it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            calibration_control_reg <= `RST_CALIBRATION;
        end else if (write_sel[0]) begin
            calibration_control_reg <= frame_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            output_configuration_reg <= `RST_OUTPUT_CONFIG;
        end else if (write_sel[1]) begin
            output_configuration_reg <= frame_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            first_channel_offset_reg <= `RST_FIRST_OFFSET;
        end else if (write_sel[2]) begin
            first_channel_offset_reg <= frame_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            first_channel_fullscale_reg <= `RST_FIRST_FULLSCALE;
        end else if (write_sel[3]) begin
            first_channel_fullscale_reg <= frame_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            extended_configuration_reg <= `RST_EXT_CONFIG;
        end else if (write_sel[4]) begin
            extended_configuration_reg <= frame_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            second_channel_offset_reg <= `RST_SECOND_OFFSET;
        end else if (write_sel[5]) begin
            second_channel_offset_reg <= frame_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            second_channel_fullscale_reg <= `RST_SECOND_FULLSCALE;
        end else if (write_sel[6]) begin
            second_channel_fullscale_reg <= frame_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sample_phase_fine_reg <= `RST_PHASE_FINE;
        end else if (write_sel[7]) begin
            sample_phase_fine_reg <= frame_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sample_phase_coarse_reg <= `RST_PHASE_COARSE;
        end else if (write_sel[8]) begin
            sample_phase_coarse_reg <= frame_data;
        end
    end

    // Non-extended mode presents defaults; the bank itself is kept
    assign active_next = extended_mode ? bank_value : default_bank;
    assign config_next = active_next.output_configuration;
    assign config_default = default_bank.output_configuration;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            active_regs <= default_bank;
        end else begin
            active_regs <= active_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_cfg.second_clock_select_n <= config_default[`BIT_SECOND_CLOCK_SEL_N];
            out_cfg.duty_stabilizer_enable <= config_default[`BIT_DUTY_STAB];
            out_cfg.ddr_clock_phase <= config_default[`BIT_DDR_PHASE];
            out_cfg.ddr_enable_n <= config_default[`BIT_DDR_EN_N];
            out_cfg.output_swing_select <= config_default[`BIT_SWING];
            out_cfg.edge_and_demux_select <= config_default[`BIT_EDGE_DEMUX];
        end else begin
            out_cfg.second_clock_select_n <= config_next[`BIT_SECOND_CLOCK_SEL_N];
            out_cfg.duty_stabilizer_enable <= config_next[`BIT_DUTY_STAB];
            out_cfg.ddr_clock_phase <= config_next[`BIT_DDR_PHASE];
            out_cfg.ddr_enable_n <= config_next[`BIT_DDR_EN_N];
            out_cfg.output_swing_select <= config_next[`BIT_SWING];
            out_cfg.edge_and_demux_select <= config_next[`BIT_EDGE_DEMUX];
        end
    end

    // Select one keeps range pair; zero reuses it as a clock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            range_output_enable <= config_default[`BIT_SECOND_CLOCK_SEL_N];
        end else begin
            range_output_enable <= config_next[`BIT_SECOND_CLOCK_SEL_N];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            second_clock_on_range_pins <= !config_default[`BIT_SECOND_CLOCK_SEL_N];
        end else begin
            second_clock_on_range_pins <= !config_next[`BIT_SECOND_CLOCK_SEL_N];
        end
    end

    // One-cycle pulse per accepted start write, extended mode and not power_down only
    assign cal_request = extended_mode && write_sel[0] && frame_data[`BIT_CAL_START]
        && !power_down;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            calibration_start <= 1'b0;
        end else begin
            calibration_start <= cal_request;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frame_written <= 1'b0;
        end else begin
            frame_written <= frame_accept;
        end
    end
endmodule : converter_serial_config_registers

//--- verif/host_serial_model.sv
`timescale 1ns/1ns
module host_serial_model (
    // Serial link pins
    output logic serial_clock,
    output logic serial_select_n,
    output logic serial_data_in
);
    initial begin
        serial_clock = 1'b0;
        serial_select_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // Half period of 6 clocks, above what the synchroniser needs
    task automatic frame(input logic [31:0] f, input logic last);
        serial_select_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            serial_data_in = f[i];
            #60 serial_clock = 1'b1;
            #60 serial_clock = 1'b0;
        end
        if (last) begin
            #60 serial_select_n = 1'b1;
            serial_data_in = ~serial_data_in;
        end
    endtask : frame
endmodule : host_serial_model

//--- verif/cfg_checker_properties.sv
`timescale 1ns/1ns
module cfg_checker (
    // Clock, reset, mode
    input wire logic clk,
    input wire logic rst_b,
    input wire logic extended_mode,
    // Outputs
    input serial_cfg_pkg::reg_bank_t active_regs,
    input serial_cfg_pkg::out_cfg_t out_cfg,
    input wire logic calibration_start,
    input wire logic second_clock_on_range_pins,
    input wire logic range_output_enable,
    input wire logic frame_written
);
    logic [15:0] cfg;
    logic [15:0] cal;
    assign cfg = active_regs.output_configuration;
    assign cal = active_regs.calibration_control;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    pin_share_a: assert property (range_output_enable == cfg[13])
        else $error("range enable wrong");
    second_clock_a: assert property (second_clock_on_range_pins == !cfg[13])
        else $error("second clock wrong");
    cfg_decode_a: assert property (out_cfg == cfg[13:8])
        else $error("config decode wrong");
    // Three cycles allow for the register stage
    mode_default_a: assert property (
        !extended_mode [*3] |-> cfg == 16'hB2FF && cal == 16'h7FFF)
        else $error("defaults missing");
    cal_pulse_a: assert property (calibration_start |=> !calibration_start)
        else $error("cal pulse long");
    cal_frame_a: assert property (calibration_start |-> frame_written ##1 cal[15])
        else $error("cal without write");
    reset_value_a: assert property ($rose(rst_b) |-> cfg == 16'hB2FF && cal == 16'h7FFF)
        else $error("reset value wrong");
    frame_gap_a: assert property (frame_written |=> !frame_written [*8])
        else $error("frames too close");
    cover property (calibration_start);
    cover property (frame_written && !range_output_enable);
    cover property ($fell(extended_mode));
endmodule : cfg_checker
bind converter_serial_config_registers cfg_checker cfg_checker_inst (.clk, .rst_b,
    .extended_mode, .active_regs, .out_cfg, .calibration_start,
    .second_clock_on_range_pins, .range_output_enable, .frame_written);

//--- verif/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic extended_mode = 1'b1;
    logic power_down = 1'b0;
    logic serial_clock, serial_select_n, serial_data_in;
    serial_cfg_pkg::reg_bank_t active_regs;
    serial_cfg_pkg::out_cfg_t out_cfg;
    logic calibration_start, second_clock_on_range_pins, range_output_enable, frame_written;
    logic [3:0] adr [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF};
    logic [15:0] val [9] = '{16'hFFFF, 16'h92FF, 16'h0102, 16'h0304, 16'h0506, 16'h0708,
        16'h090A, 16'h0B0C, 16'h0D0E};
    int n_fail = 0;
    int checked = 0;
    int n_cal = 0;
    int n_frame = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        n_cal <= n_cal + int'(calibration_start === 1'b1);
        n_frame <= n_frame + int'(frame_written === 1'b1);
    end
    converter_serial_config_registers converter_serial_config_registers_inst (.clk, .rst_b,
        .extended_mode, .power_down, .serial_clock, .serial_select_n, .serial_data_in,
        .active_regs, .out_cfg, .calibration_start, .second_clock_on_range_pins,
        .range_output_enable, .frame_written);
    host_serial_model host_serial_model_inst (.serial_clock, .serial_select_n, .serial_data_in);
    task automatic chk(input string what, input logic [143:0] exp, input logic [143:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [143:0] bank_exp();
        return {val[0], val[1], val[2], val[3], val[4], val[5], val[6], val[7], val[8]};
    endfunction : bank_exp
    task automatic wr(input logic [11:0] h, input logic [3:0] a, input logic [15:0] d,
        input logic last);
        host_serial_model_inst.frame({h, a, d}, last);
        repeat (12) @(posedge clk);
        #1;
    endtask : wr
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("reset bank", {16'h7FFF, 16'hB2FF, 112'h0}, active_regs);
        chk("reset cfg", 6'h32, out_cfg);
        $display("test reset done");
        foreach (adr[i]) wr(12'h001, adr[i], val[i], i == 8);
        chk("bank", bank_exp(), active_regs);
        chk("frames", 9, n_frame);
        chk("cal pulses", 1, n_cal);
        chk("pin share", 2'b10, {second_clock_on_range_pins, range_output_enable});
        chk("out cfg", 6'h12, out_cfg);
        $display("test full load done");
        wr(12'h001, 4'h4, 16'h1234, 1'b0);
        wr(12'h003, 4'h1, 16'h1234, 1'b1);
        chk("refused", bank_exp(), active_regs);
        chk("frames", 10, n_frame);
        $display("test refusal done");
        power_down = 1'b1;
        wr(12'h001, 4'h0, 16'hFFFF, 1'b0);
        wr(12'h001, 4'h1, 16'hB2FF, 1'b1);
        val[1] = 16'hB2FF;
        power_down = 1'b0;
        chk("cal pulses", 1, n_cal);
        chk("frames", 12, n_frame);
        chk("bank kept", bank_exp(), active_regs);
        chk("pin share", 2'b01, {second_clock_on_range_pins, range_output_enable});
        chk("out cfg", 6'h32, out_cfg);
        $display("test power down done");
        extended_mode = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("pin mode", {16'h7FFF, 16'hB2FF, 112'h0}, active_regs);
        chk("pin mode cfg", 6'h32, out_cfg);
        extended_mode = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("mode back", bank_exp(), active_regs);
        $display("test mode done");
        complete_run;
    end
endmodule : testbench
